// ---- core/diag_event_mask_latch.sv ----
// Purpose: diagnostic event status with enable and latch masks, button decode
// Assumes: event inputs synchronous to clk_sys, button debounced
// Notes: persistent copy modelled as a saved register pair with a save strobe
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
module diag_event_mask_latch
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// event conditions and panel
	input wire logic [15:0] eventCond,
	input wire logic pushButton,
	input wire logic [1:0] portMode,
	// outputs
	output logic amberLed,
	output logic nvSave,
	output logic [31:0] nvData,
	output logic irq
);
	//------------------------------------------------
	// bus slave
	//------------------------------------------------
	typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_t;
	bus_state_t busSt_ff;
	logic [31:0] rdata_ff;
	logic waitReq_ff;
	logic wrStb;
	logic [15:0] status;
	logic [15:0] maskAct_ff, latchAct_ff, maskEdit_ff, latchEdit_ff;
	logic [2:0] irqStat_ff, irqMask_ff;
	logic resetPend_ff;
	logic irq_ff, save_ff;
	logic [31:0] nvData_ff;
	diag_pkg::cmd_t cmd;
	logic flashDone;
	logic amber;

	assign cmd = writedata[8:0];
	// one wait cycle per access keeps read data registered
	// writes commit on the edge that completes the transfer
	assign wrStb = (busSt_ff == BUS_ACK) && write;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			busSt_ff <= BUS_IDLE;
			waitReq_ff <= 1'b1;
		end
		else
		begin
			case (busSt_ff)
				BUS_IDLE:
				begin
					if (read || write)
					begin
						busSt_ff <= BUS_ACK;
						waitReq_ff <= 1'b0;
					end
				end
				BUS_ACK:
				begin
					busSt_ff <= BUS_IDLE;
					waitReq_ff <= 1'b1;
				end
				default:
				begin
					busSt_ff <= BUS_IDLE;
					waitReq_ff <= 1'b1;
				end
			endcase
		end
	end
	assign waitrequest = waitReq_ff;

	// read mux, unmapped reads return zero
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rdata_ff <= 32'h0;
		else if (busSt_ff == BUS_IDLE && read)
		begin
			case (address)
				diag_pkg::OFS_STATUS: rdata_ff <= {16'h0, status};
				diag_pkg::OFS_MASK_ACT: rdata_ff <= {16'h0, maskAct_ff};
				diag_pkg::OFS_LATCH_ACT: rdata_ff <= {16'h0, latchAct_ff};
				diag_pkg::OFS_MASK_EDIT: rdata_ff <= {16'h0, maskEdit_ff};
				diag_pkg::OFS_LATCH_EDIT: rdata_ff <= {16'h0, latchEdit_ff};
				diag_pkg::OFS_COMMAND: rdata_ff <= {31'h0, resetPend_ff};
				diag_pkg::OFS_IRQ_STAT: rdata_ff <= {29'h0, irqStat_ff};
				diag_pkg::OFS_IRQ_MASK: rdata_ff <= {29'h0, irqMask_ff};
				diag_pkg::OFS_PORT_MODE: rdata_ff <= {30'h0, portMode};
				default: rdata_ff <= 32'h0;
			endcase
		end
	end
	assign readdata = rdata_ff;

	//------------------------------------------------
	// edited and active settings
	//------------------------------------------------
	// menu edits stay private until accepted, as on the panel
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			maskEdit_ff <= diag_pkg::MASK_DEFAULT;
			latchEdit_ff <= diag_pkg::LATCH_DEFAULT;
		end
		else if (wrStb && address == diag_pkg::OFS_COMMAND)
		begin
			if (cmd.tglMask)
				maskEdit_ff[cmd.sel] <= ~maskEdit_ff[cmd.sel];
			if (cmd.tglLatch)
				latchEdit_ff[cmd.sel] <= ~latchEdit_ff[cmd.sel];
		end
	end
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			maskAct_ff <= diag_pkg::MASK_DEFAULT;
			latchAct_ff <= diag_pkg::LATCH_DEFAULT;
			save_ff <= 1'b0;
			nvData_ff <= 32'h0;
		end
		else
		begin
			save_ff <= 1'b0;
			if (wrStb && address == diag_pkg::OFS_COMMAND && cmd.accept)
			begin
				maskAct_ff <= maskEdit_ff;
				latchAct_ff <= latchEdit_ff;
				nvData_ff <= {latchEdit_ff, maskEdit_ff};
				save_ff <= 1'b1;
			end
		end
	end
	assign nvSave = save_ff;
	assign nvData = nvData_ff;

	// reset needs a request then a yes; any other command register write drops it
	logic clearAll;
	assign clearAll = wrStb && address == diag_pkg::OFS_COMMAND && cmd.resetYes
		&& resetPend_ff;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			resetPend_ff <= 1'b0;
		else if (wrStb && address == diag_pkg::OFS_COMMAND)
			resetPend_ff <= cmd.resetReq;
	end

	//------------------------------------------------
	// status bits
	//------------------------------------------------
	for (genvar i = 0; i < diag_pkg::NUM_EVENTS; i++)
	begin : g_evt
		event_bit u_bit
		(
			.clk_sys(clk_sys),
			.resetn(resetn),
			.cond(eventCond[i]),
			.enable(maskAct_ff[i]),
			.latchEn(latchAct_ff[i]),
			.clearAll(clearAll),
			.status_ff(status[i])
		);
	end

	//------------------------------------------------
	// push-button decode
	//------------------------------------------------
	localparam logic [29:0] SHORT = 30'(diag_pkg::SHORT_PRESS_CYC);
	logic [29:0] press_ff;
	logic btnQ_ff, flashStart_ff;
	// long presses belong to other logic; only short release acts here
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			press_ff <= 30'h0;
			btnQ_ff <= 1'b0;
			flashStart_ff <= 1'b0;
		end
		else
		begin
			btnQ_ff <= pushButton;
			flashStart_ff <= btnQ_ff && !pushButton && press_ff < SHORT;
			if (pushButton)
				press_ff <= (press_ff == SHORT) ? press_ff : press_ff + 30'h1;
			else
				press_ff <= 30'h0;
		end
	end
	port_flasher u_flash
	(
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start(flashStart_ff),
		.portMode(portMode),
		.amber_ff(amber),
		.done_ff(flashDone)
	);
	logic amber_ff;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			amber_ff <= 1'b0;
		else
			amber_ff <= amber;
	end
	assign amberLed = amber_ff;

	//------------------------------------------------
	// interrupts
	//------------------------------------------------
	logic [15:0] statusQ_ff;
	logic [2:0] irqSet;
	assign irqSet = {flashDone, save_ff, |(status & ~statusQ_ff)};
	// set wins over write-one-to-clear
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			statusQ_ff <= diag_pkg::ZERO16;
			irqStat_ff <= diag_pkg::IRQ_ZERO;
			irqMask_ff <= diag_pkg::IRQ_ZERO;
			irq_ff <= 1'b0;
		end
		else
		begin
			statusQ_ff <= status;
			if (wrStb && address == diag_pkg::OFS_IRQ_STAT)
				irqStat_ff <= (irqStat_ff & ~writedata[2:0]) | irqSet;
			else
				irqStat_ff <= irqStat_ff | irqSet;
			if (wrStb && address == diag_pkg::OFS_IRQ_MASK)
				irqMask_ff <= writedata[2:0];
			irq_ff <= |(irqStat_ff & irqMask_ff);
		end
	end
	assign irq = irq_ff;

	//------------------------------------------------
	// checks
	//------------------------------------------------
	sequence reset_confirm_s;
		wrStb && address == diag_pkg::OFS_COMMAND && cmd.resetYes && resetPend_ff;
	endsequence
	reset_clears_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		reset_confirm_s |=> ((status & ~$past(eventCond & maskAct_ff)) == 16'h0))
		else $error("status not cleared");
	no_confirm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wrStb && address == diag_pkg::OFS_COMMAND && cmd.resetYes && !resetPend_ff)
		|=> ((status & $past(status & latchAct_ff)) == $past(status & latchAct_ff)))
		else $error("unconfirmed reset");
	accept_save_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wrStb && address == diag_pkg::OFS_COMMAND && cmd.accept)
		|=> nvSave && nvData == {$past(latchEdit_ff), $past(maskEdit_ff)})
		else $error("accept did not save");
	toggle_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wrStb && address == diag_pkg::OFS_COMMAND && cmd.tglMask)
		|=> $countones(maskEdit_ff ^ $past(maskEdit_ff)) == 1)
		else $error("toggle touched other bits");
	long_press_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(press_ff >= SHORT && btnQ_ff && !pushButton) |=> !flashStart_ff)
		else $error("long press started flash");
	masked_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(status[0]) |-> $past(maskAct_ff[0]))
		else $error("masked event shown");
endmodule

// ---- core/diag_pkg.sv ----
// Purpose: shared constants and types for the diagnostic event block
// Assumes: 100 MHz system clock
// Notes: all register offsets are word indices on a 32-bit Avalon-MM slave
package diag_pkg;
	localparam int NUM_EVENTS = 16;
	localparam logic [15:0] MASK_DEFAULT = 16'h0001;
	localparam logic [15:0] LATCH_DEFAULT = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// register word offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_MASK_ACT = 4'h1;
	localparam logic [3:0] OFS_LATCH_ACT = 4'h2;
	localparam logic [3:0] OFS_MASK_EDIT = 4'h3;
	localparam logic [3:0] OFS_LATCH_EDIT = 4'h4;
	localparam logic [3:0] OFS_COMMAND = 4'h5;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
	localparam logic [3:0] OFS_PORT_MODE = 4'h8;
	// command register fields
	localparam int CMD_SEL_LSB = 0;
	localparam int CMD_TGL_MASK = 4;
	localparam int CMD_TGL_LATCH = 5;
	localparam int CMD_ACCEPT = 6;
	localparam int CMD_RESET_REQ = 7;
	localparam int CMD_RESET_YES = 8;
	// interrupt status bit positions
	localparam int IRQ_NEW_EVENT = 0;
	localparam int IRQ_SAVED = 1;
	localparam int IRQ_FLASH_DONE = 2;
	localparam logic [2:0] IRQ_ZERO = 3'h0;
	// timing
	localparam longint CLK_HZ = 100_000_000;
	localparam longint SHORT_PRESS_MS = 6000;
	localparam longint FLASH_HALF_MS = 1000;
	localparam longint SHORT_PRESS_CYC = SHORT_PRESS_MS * CLK_HZ / 1000;
	localparam longint FLASH_HALF_CYC = FLASH_HALF_MS * CLK_HZ / 1000;
	// port modes
	localparam logic [1:0] PORT_OFF = 2'h0;
	localparam logic [1:0] PORT_232 = 2'h1;
	localparam logic [1:0] PORT_485 = 2'h2;
	// first member is the top bit: reset yes at bit 8 down to select at bits 3:0
	typedef struct packed {
		logic resetYes;
		logic resetReq;
		logic accept;
		logic tglLatch;
		logic tglMask;
		logic [3:0] sel;
	} cmd_t;
	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] latch;
	} cfg_t;
endpackage

// ---- core/event_bit.sv ----
// Purpose: one diagnostic status bit with enable and latch handling
// Assumes: condition synchronous to clk_sys
// Notes: set beats clear in the same cycle
`timescale 1ns/100ps
module event_bit
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// control
	input wire logic cond,
	input wire logic enable,
	input wire logic latchEn,
	input wire logic clearAll,
	// state
	output logic status_ff
);
	logic nxt_status;
	// live, latched or cleared status
	always_comb
	begin
		nxt_status = status_ff;
		if (clearAll)
			nxt_status = 1'b0;
		if (!latchEn)
			nxt_status = enable & cond;
		else if (enable && cond)
			nxt_status = 1'b1;
		else if (!enable)
			nxt_status = clearAll ? 1'b0 : status_ff;
	end
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			status_ff <= 1'b0;
		else
			status_ff <= nxt_status;
	end
	// masked event never sets the bit
	masked_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!enable && !$past(status_ff) && $past(resetn)) |-> !status_ff || $past(enable))
		else $error("masked event set status");
	latch_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(status_ff && latchEn && !clearAll) |=> status_ff)
		else $error("latched status dropped");
	live_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!latchEn) |=> (status_ff == $past(enable & cond)))
		else $error("live status mismatch");
	set_wins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(clearAll && enable && cond) |=> status_ff)
		else $error("clear beat new event");
endmodule

// ---- core/port_flasher.sv ----
// Purpose: flash amber indicator 1..3 times for the port mode
// Assumes: start is a one-cycle pulse
// Notes: half-period from package; start ignored while busy
`timescale 1ns/100ps
module port_flasher
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// control
	input wire logic start,
	input wire logic [1:0] portMode,
	// outputs
	output logic amber_ff,
	output logic done_ff
);
	localparam logic [27:0] HALF = 28'(diag_pkg::FLASH_HALF_CYC - 1);
	logic [27:0] tick_ff;
	logic [2:0] left_ff;
	logic busy_ff;
	// count flashes, each on then off for one half period
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tick_ff <= 28'h0;
			left_ff <= 3'h0;
			busy_ff <= 1'b0;
			amber_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			if (!busy_ff)
			begin
				if (start)
				begin
					busy_ff <= 1'b1;
					amber_ff <= 1'b1;
					tick_ff <= 28'h0;
					left_ff <= 3'({1'b0, portMode} + 3'h1);
				end
			end
			else if (tick_ff == HALF)
			begin
				tick_ff <= 28'h0;
				if (amber_ff)
				begin
					amber_ff <= 1'b0;
					left_ff <= left_ff - 3'h1;
				end
				else if (left_ff == 3'h0)
				begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
				else
					amber_ff <= 1'b1;
			end
			else
				tick_ff <= tick_ff + 28'h1;
		end
	end
	count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(start && !busy_ff) |=> (left_ff == $past({1'b0, portMode}) + 3'h1))
		else $error("flash count wrong");
endmodule

// ---- tb/operator_model.sv ----
// Purpose: operator at the front panel pressing the push-button
// Assumes: bench calls press with a hold length in clock cycles
// Notes: button rests low between presses; holds stay far below six seconds
`timescale 1ns/100ps
module operator_model
(
	// clock
	input wire logic clk_sys,
	// panel button
	output logic pushButton
);
	// ----------------------------------------
	// button press
	// ----------------------------------------
	// released level at time zero so the decoder sees no phantom press
	initial pushButton = 1'b0;
	// brief hold only, the long-press functions are out of scope
	task automatic press(input int holdCyc);
		@(posedge clk_sys);
		pushButton <= 1'b1;
		repeat (holdCyc) @(posedge clk_sys);
		pushButton <= 1'b0;
	endtask
endmodule

// ---- tb/tb_diag_event_mask_latch.sv ----
// Purpose: self-checking bench for the diagnostic event block
// Assumes: one 100 MHz clock, bus reads checked through an expectation queue
// Notes: flash half-periods of one second are too long to watch, only the first flash is seen
`timescale 1ns/100ps
module tb_diag_event_mask_latch;
	logic clk_sys, resetn, read, write, pushButton, waitrequest, amberLed, nvSave, irq;
	logic [3:0] address;
	logic [31:0] writedata, readdata, nvData;
	logic [15:0] eventCond, mAct, lAct, mEdit, lEdit, stat, c;
	logic [1:0] portMode;
	logic [31:0] expQ[$];
	logic [31:0] nvQ[$];
	int errors, cmp_count, seed, n;
	// ----------------------------------------
	// clock and instances
	// ----------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	diag_event_mask_latch diag_event_mask_latch_inst (.clk_sys(clk_sys), .resetn(resetn),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .eventCond(eventCond),
		.pushButton(pushButton), .portMode(portMode), .amberLed(amberLed),
		.nvSave(nvSave), .nvData(nvData), .irq(irq));
	operator_model operator_model_inst (.clk_sys(clk_sys), .pushButton(pushButton));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic conclude();
		$display("counts: %0d compares, %0d errors", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (waitrequest !== 1'b0 && k < 50);
		if (waitrequest !== 1'b0)
		begin
			errors++;
			$display("mismatch at %0t: expected %h got %h", $time, 1'b0, waitrequest);
			conclude();
		end
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// kind 0 edits the enable mask, kind 1 the latch register
	task automatic tgl(input int kind, input int i);
		wr(diag_pkg::OFS_COMMAND, (32'h1 << (diag_pkg::CMD_TGL_MASK + kind)) | 32'(i));
		if (kind == 0)
			mEdit[i] = ~mEdit[i];
		else
			lEdit[i] = ~lEdit[i];
	endtask
	// edit both registers to a target by single toggles, then accept
	task automatic cfg(input logic [15:0] tm, input logic [15:0] tl);
		for (int i = 0; i < 16; i++)
		begin
			if (mEdit[i] !== tm[i]) tgl(0, i);
			if (lEdit[i] !== tl[i]) tgl(1, i);
		end
		rd(diag_pkg::OFS_MASK_EDIT, {16'h0, mEdit});
		rd(diag_pkg::OFS_LATCH_EDIT, {16'h0, lEdit});
		rd(diag_pkg::OFS_MASK_ACT, {16'h0, mAct});
		nvQ.push_back({tl, tm});
		wr(diag_pkg::OFS_COMMAND, 32'h1 << diag_pkg::CMD_ACCEPT);
		mAct = tm;
		lAct = tl;
		rd(diag_pkg::OFS_MASK_ACT, {16'h0, mAct});
		rd(diag_pkg::OFS_LATCH_ACT, {16'h0, lAct});
	endtask
	// drive conditions and read status back
	task automatic setCond(input logic [15:0] x);
		@(posedge clk_sys);
		eventCond <= x;
		stat = (stat & lAct) | (x & mAct);
		repeat (2) @(posedge clk_sys);
		rd(diag_pkg::OFS_STATUS, {16'h0, stat});
	endtask
	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	// pops the oldest note whenever read data or a save appears
	always @(posedge clk_sys)
	begin
		if (read === 1'b1 && waitrequest === 1'b0)
		begin
			if (expQ.size() == 0)
			begin
				errors++;
				$display("mismatch at %0t: expected %h got %h", $time, 32'h0, readdata);
			end
			else cmp(expQ.pop_front(), readdata);
		end
		if (nvSave === 1'b1)
		begin
			if (nvQ.size() == 0)
			begin
				errors++;
				$display("mismatch at %0t: expected %h got %h", $time, 32'h0, nvData);
			end
			else cmp(nvQ.pop_front(), nvData);
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed = 4069;
		errors = 0;
		cmp_count = 0;
		resetn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		eventCond = 16'h0;
		portMode = 2'(($random(seed) & 32'h7fffffff) % 3);
		mAct = 16'h0001;
		mEdit = 16'h0001;
		lAct = 16'h0000;
		lEdit = 16'h0000;
		stat = 16'h0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(diag_pkg::OFS_MASK_ACT, 32'h1);
		rd(diag_pkg::OFS_MASK_EDIT, 32'h1);
		rd(diag_pkg::OFS_LATCH_ACT, 32'h0);
		rd(diag_pkg::OFS_LATCH_EDIT, 32'h0);
		rd(diag_pkg::OFS_STATUS, 32'h0);
		rd(4'h9, 32'h0);
		rd(diag_pkg::OFS_PORT_MODE, {30'h0, portMode});
		$display("test reset values done");
		setCond(16'($random(seed)) & 16'hfffe);
		setCond(16'h8001);
		setCond(16'h0000);
		wr(diag_pkg::OFS_STATUS, 32'hffff);
		rd(diag_pkg::OFS_STATUS, 32'h0);
		$display("test enable and follow done");
		tgl(0, 15);
		rd(diag_pkg::OFS_MASK_EDIT, {16'h0, mEdit});
		rd(diag_pkg::OFS_MASK_ACT, {16'h0, mAct});
		tgl(0, 15);
		tgl(1, 0);
		rd(diag_pkg::OFS_LATCH_EDIT, {16'h0, lEdit});
		tgl(1, 0);
		wr(diag_pkg::OFS_IRQ_MASK, 32'h0);
		wr(diag_pkg::OFS_IRQ_STAT, 32'h7);
		rd(diag_pkg::OFS_IRQ_STAT, 32'h0);
		cfg(16'($random(seed)) | 16'h0001, 16'($random(seed)));
		rd(diag_pkg::OFS_IRQ_STAT, 32'h2);
		cmp(32'h0, {31'h0, irq});
		wr(diag_pkg::OFS_IRQ_MASK, 32'h2);
		rd(diag_pkg::OFS_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk_sys);
		cmp(32'h1, {31'h0, irq});
		wr(diag_pkg::OFS_IRQ_STAT, 32'h2);
		repeat (3) @(posedge clk_sys);
		cmp(32'h0, {31'h0, irq});
		$display("test toggle accept irq done");
		repeat (3)
		begin
			setCond(16'($random(seed)));
			setCond(16'h0000);
		end
		$display("test latching done");
		c = 16'($random(seed));
		setCond(c);
		wr(diag_pkg::OFS_COMMAND, 32'h1 << diag_pkg::CMD_RESET_REQ);
		rd(diag_pkg::OFS_COMMAND, 32'h1);
		wr(diag_pkg::OFS_COMMAND, 32'h0);
		wr(diag_pkg::OFS_COMMAND, 32'h1 << diag_pkg::CMD_RESET_YES);
		rd(diag_pkg::OFS_STATUS, {16'h0, stat});
		wr(diag_pkg::OFS_COMMAND, 32'h1 << diag_pkg::CMD_RESET_REQ);
		wr(diag_pkg::OFS_COMMAND, 32'h1 << diag_pkg::CMD_RESET_YES);
		stat = c & mAct;
		rd(diag_pkg::OFS_STATUS, {16'h0, stat});
		setCond(16'h0000);
		$display("test status reset done");
		operator_model_inst.press(40);
		cmp(32'h0, {31'h0, amberLed});
		n = 0;
		while (amberLed !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		cmp(32'h1, {31'h0, amberLed});
		rd(diag_pkg::OFS_STATUS, {16'h0, stat});
		rd(diag_pkg::OFS_MASK_ACT, {16'h0, mAct});
		$display("test short press done");
		repeat (3) @(posedge clk_sys);
		if (expQ.size() != 0 || nvQ.size() != 0)
		begin
			errors++;
			$display("mismatch at %0t: expected %h got %h", $time, 0, expQ.size() + nvQ.size());
		end
		conclude();
	end
endmodule
